// ===== rtl/pegs_gate_sched.sv
`timescale 1ns/1ps
// Functional notes
// - Control bit 7 set lets gated traffic use cut-through; reset clear.
// - Restricted bit 6 set holds gated frames until the open period.
// - Restricted bit clear lets gated frames go at any time; reset clear.
// - Bits 1:0 pick cycle start: none, internal second, pps, crossing.
// - Entry bits 31:29 hold event code: closed, guard, open, repeat.
// - Entry bits 28:0 hold event time in system clock cycles, reset zero.
// - Seven-bit event index in bits 6:0, bit 7 reads zero.
// - Gated behaviour applies only when the shaper mode field is 10.
module pegs_gate_sched
  import pegs_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic        CE_I,
  input  wire logic [11:0] ADDR_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic [1:0]  SHAPER_MODE_I,
  input  wire logic        REF_CROSS_I,
  input  wire logic        PPS_I,
  input  wire logic        SEC_TICK_I,
  output logic      [7:0]  RDATA_O,
  output logic             CUT_THROUGH_O,
  output logic             TX_ALLOW_O,
  output logic             GATE_OPEN_O,
  output logic             GUARD_O
);

  // Byte lane 0 is the most significant byte of the entry
  function automatic logic [1:0] lane_of(input logic [11:0] a);
    return 2'(a - PEGS_OFS_ENTRY0);
  endfunction : lane_of

  logic [7:0]   ctrl;
  logic [6:0]   idx;
  pegs_entry_t  table_mem [PEGS_EVENTS];
  logic [6:0]   ptr;
  logic [28:0]  cnt;
  logic         running;
  pegs_gate_t   gate;

  // Address decode
  wire         sel_ctrl  = (ADDR_I == PEGS_OFS_CTRL);
  wire         sel_index = (ADDR_I == PEGS_OFS_INDEX);
  wire         sel_entry = (ADDR_I >= PEGS_OFS_ENTRY0) &&
                           (ADDR_I <= PEGS_OFS_ENTRY3);
  wire [1:0]   wr_lane   = lane_of(ADDR_I);
  wire [4:0]   wr_shift  = {~wr_lane, 3'b000};
  wire [31:0]  cur_entry = table_mem[idx];
  wire [31:0]  rd_word   = cur_entry >> wr_shift;
  wire [7:0]   next_rdata = sel_ctrl  ? ctrl :
                            sel_index ? {1'b0, idx} :
                            sel_entry ? rd_word[7:0] : 8'h00;

  // Mode and control decode
  wire         gated     = (SHAPER_MODE_I == PEGS_SHAPER_GATED);
  wire         restrict_tx = ctrl[PEGS_CTRL_RSTR_BIT];
  wire [1:0]   ref_sel   = ctrl[PEGS_CTRL_REF_LSB +: 2];
  wire         restart   = (ref_sel == PEGS_REF_CROSS && REF_CROSS_I) ||
                           (ref_sel == PEGS_REF_PPS   && PPS_I) ||
                           (ref_sel == PEGS_REF_SEC   && SEC_TICK_I);
  pegs_entry_t ev;
  assign ev = table_mem[ptr];
  wire         hit       = running && (cnt == ev.cycles);
  wire         next_cut  = gated && ctrl[PEGS_CTRL_CUT_BIT];
  // Holding only matters while gated and restricted; else always free
  wire         next_allow = !gated || !restrict_tx || gate.open;

  // Register writes; reserved control bits stay zero
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl <= PEGS_CTRL_RST;
      idx  <= PEGS_INDEX_RST;
    end else if (CE_I && WR_I) begin
      if (sel_ctrl) begin
        ctrl <= WDATA_I & PEGS_CTRL_WMASK;
      end
      if (sel_index) begin
        idx <= WDATA_I[6:0];
      end
    end
  end

  // Event table; a byte write touches only its own lane
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      for (int i = 0; i < PEGS_EVENTS; i++) begin
        table_mem[i] <= {PEGS_EV_CLOSED, PEGS_TIME_RST};
      end
    end else if (CE_I && WR_I && sel_entry) begin
      table_mem[idx][wr_shift +: 8] <= WDATA_I;
    end
  end

  // Schedule engine: a reference restart beats any event in that cycle
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      running <= 1'b0;
      cnt     <= 29'h0000_0000;
      ptr     <= 7'h00;
      gate    <= '0;
    end else if (CE_I) begin
      if (ref_sel == PEGS_REF_NONE) begin
        running <= 1'b0;
        gate    <= '0;
      end else if (restart) begin
        running <= 1'b1;
        cnt     <= 29'h0000_0000;
        ptr     <= 7'h00;
      end else if (hit) begin
        unique case (ev.code)
          PEGS_EV_CLOSED: gate <= '{open: 1'b0, guard: 1'b0};
          PEGS_EV_GUARD:  gate.guard <= 1'b1;
          PEGS_EV_OPEN:   gate <= '{open: 1'b1, guard: 1'b0};
          default: ;                                          // Reserved, skipped
        endcase
        if (ev.code == PEGS_EV_REPEAT) begin
          cnt <= 29'h0000_0000;
          ptr <= 7'h00;
        end else begin
          cnt <= cnt + 29'h0000_0001;
          ptr <= ptr + 7'h01;
        end
      end else if (running) begin
        cnt <= cnt + 29'h0000_0001;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      RDATA_O       <= 8'h00;
      CUT_THROUGH_O <= 1'b0;
      TX_ALLOW_O    <= 1'b1;
      GATE_OPEN_O   <= 1'b0;
      GUARD_O       <= 1'b0;
    end else if (CE_I) begin
      RDATA_O       <= RD_I ? next_rdata : 8'h00;
      CUT_THROUGH_O <= next_cut;
      TX_ALLOW_O    <= next_allow;
      GATE_OPEN_O   <= gate.open;
      GUARD_O       <= gate.guard;
    end
  end

  a_cut_thru_on: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    CE_I && gated && ctrl[PEGS_CTRL_CUT_BIT] |=> CUT_THROUGH_O)
    else $error("cut-through not granted");

  a_hold_closed: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    CE_I && gated && restrict_tx && !gate.open |=> !TX_ALLOW_O)
    else $error("gated frame sent while closed");

  a_free_send: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    CE_I && !restrict_tx |=> TX_ALLOW_O)
    else $error("unrestricted frame held");

  sequence s_pps_seen;
    CE_I && ref_sel == PEGS_REF_PPS && PPS_I;
  endsequence
  a_pps_restart: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_pps_seen |=> running && cnt == 29'h0000_0000 && ptr == 7'h00)
    else $error("pps did not restart cycle");

  a_no_ref_idle: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    CE_I && ref_sel == PEGS_REF_NONE |=> !running)
    else $error("engine runs without reference");

  sequence s_open_hit;
    CE_I && ref_sel != PEGS_REF_NONE && !restart && hit &&
    ev.code == PEGS_EV_OPEN;
  endsequence
  a_open_event: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_open_hit |=> gate.open && !gate.guard)
    else $error("open event not applied");

  // Guard keeps the open state as it was; only the guard flag rises
  sequence s_guard_hit;
    CE_I && ref_sel != PEGS_REF_NONE && !restart && hit &&
    ev.code == PEGS_EV_GUARD;
  endsequence
  a_guard_event: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_guard_hit |=> gate.guard && gate.open == $past(gate.open))
    else $error("guard event not applied");

  sequence s_closed_hit;
    CE_I && ref_sel != PEGS_REF_NONE && !restart && hit &&
    ev.code == PEGS_EV_CLOSED;
  endsequence
  a_closed_event: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_closed_hit |=> !gate.open && !gate.guard)
    else $error("closed event not applied");

  // Repeat must rewind both the time base and the table pointer together
  sequence s_repeat_hit;
    CE_I && ref_sel != PEGS_REF_NONE && !restart && hit &&
    ev.code == PEGS_EV_REPEAT;
  endsequence
  a_repeat_wrap: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    s_repeat_hit |=> cnt == 29'h0000_0000 && ptr == 7'h00)
    else $error("repeat event did not rewind");

  a_time_count: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    CE_I && running && !hit && !restart && ref_sel != PEGS_REF_NONE
    |=> cnt == $past(cnt) + 29'h0000_0001)
    else $error("cycle counter stalled");

  a_index_rw: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    CE_I && WR_I && sel_index ##1 CE_I && !WR_I ##1 CE_I && RD_I && sel_index
    |=> RDATA_O == ($past(WDATA_I, 3) & PEGS_INDEX_WMASK))
    else $error("index readback wrong");

  a_mode_gate: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    CE_I && !gated |=> TX_ALLOW_O && !CUT_THROUGH_O)
    else $error("ungated port shaped");

  a_entry_write: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    CE_I && WR_I && ADDR_I == PEGS_OFS_ENTRY3
    |=> table_mem[$past(idx)][7:0] == $past(WDATA_I))
    else $error("entry byte not stored");

endmodule : pegs_gate_sched

// ===== shared/pegs_pkg.sv
package pegs_pkg;

  // Register byte offsets within the port page
  localparam logic [11:0] PEGS_OFS_CTRL   = 12'h0920;
  localparam logic [11:0] PEGS_OFS_INDEX  = 12'h0923;
  localparam logic [11:0] PEGS_OFS_ENTRY0 = 12'h0924;
  localparam logic [11:0] PEGS_OFS_ENTRY3 = 12'h0927;

  // Control register fields
  localparam int PEGS_CTRL_CUT_BIT  = 7;
  localparam int PEGS_CTRL_RSTR_BIT = 6;
  localparam int PEGS_CTRL_REF_LSB  = 0;
  localparam logic [7:0] PEGS_CTRL_WMASK = 8'hC3;
  localparam logic [7:0] PEGS_CTRL_RST   = 8'h00;
  localparam logic [7:0] PEGS_INDEX_WMASK = 8'h7F;
  localparam logic [6:0] PEGS_INDEX_RST   = 7'h00;

  // Reference select values
  localparam logic [1:0] PEGS_REF_NONE  = 2'b00;
  localparam logic [1:0] PEGS_REF_SEC   = 2'b01;
  localparam logic [1:0] PEGS_REF_PPS   = 2'b10;
  localparam logic [1:0] PEGS_REF_CROSS = 2'b11;

  // Egress shaper mode selecting the scheduled gate shaper
  localparam logic [1:0] PEGS_SHAPER_GATED = 2'b10;

  // Event codes
  localparam logic [2:0] PEGS_EV_CLOSED = 3'b000;
  localparam logic [2:0] PEGS_EV_GUARD  = 3'b001;
  localparam logic [2:0] PEGS_EV_OPEN   = 3'b010;
  localparam logic [2:0] PEGS_EV_REPEAT = 3'b111;

  localparam int PEGS_EVENTS = 128;
  localparam logic [28:0] PEGS_TIME_RST = 29'h0000_0000;

  typedef struct packed {
    logic [2:0]  code;
    logic [28:0] cycles;
  } pegs_entry_t;

  typedef struct packed {
    logic open;
    logic guard;
  } pegs_gate_t;

endpackage : pegs_pkg

// ===== bench/test_pegs_gate_sched.sv
`timescale 1ns/1ps
module test_pegs_gate_sched;
  import pegs_pkg::*;
  localparam int MAX_CYC = 3000;
  logic        clk_i = 1'b0, arst_n_i = 1'b0, ce_i = 1'b1;
  logic [11:0] addr_i = '0;
  logic        wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0]  wdata_i = '0, rdata_o;
  logic [1:0]  shaper_i = '0;
  logic [2:0]  pulse_i = '0;
  logic        cut_o, allow_o, open_o, guard_o;
  int          num_errors = 0, tests_run = 0, cyc = 0, base = 0;
  int          ns [8] = '{4, 5, 7, 8, 10, 11, 17, 18};
  logic [2:0]  ev [8] = '{3'h0, 3'h5, 3'h5, 3'h7, 3'h7, 3'h0, 3'h0, 3'h5};
  pegs_entry_t sched [4];

  pegs_gate_sched i_dut (.CLK_I(clk_i), .ARST_N_I(arst_n_i), .CE_I(ce_i),
    .ADDR_I(addr_i), .WR_I(wr_i), .RD_I(rd_i), .WDATA_I(wdata_i),
    .SHAPER_MODE_I(shaper_i), .REF_CROSS_I(pulse_i[2]), .PPS_I(pulse_i[1]),
    .SEC_TICK_I(pulse_i[0]), .RDATA_O(rdata_o), .CUT_THROUGH_O(cut_o),
    .TX_ALLOW_O(allow_o), .GATE_OPEN_O(open_o), .GUARD_O(guard_o));

  // 200 MHz system clock
  always #2.5 clk_i = ~clk_i;

  // Cycle count, also cuts a hung run short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == MAX_CYC) begin
      num_errors++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One idle edge between accesses keeps strobes from toggling twice
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the taking edge
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    chk(rdata_o, exp);
  endtask : rd

  // Entry bytes go most significant first
  task automatic entry(input logic [6:0] idx, input logic [31:0] v,
                       input bit do_wr);
    wr(PEGS_OFS_INDEX, {1'b0, idx});
    for (int b = 0; b < 4; b++) begin
      if (do_wr) wr(PEGS_OFS_ENTRY0 + 12'(b), v[31-8*b -: 8]);
      else rd(PEGS_OFS_ENTRY0 + 12'(b), v[31-8*b -: 8]);
    end
  endtask : entry

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  initial begin
    sched = '{{PEGS_EV_OPEN, 29'h0000_0003}, {PEGS_EV_GUARD, 29'h0000_0006},
              {PEGS_EV_CLOSED, 29'h0000_0009}, {PEGS_EV_REPEAT, 29'h0000_000C}};
    repeat (2) @(negedge clk_i);
    arst_n_i = 1'b1;
    chk(cut_o, 1'b0);
    chk(allow_o, 1'b1);
    rd(PEGS_OFS_CTRL, 8'h00);
    rd(PEGS_OFS_INDEX, 8'h00);
    entry(7'h7F, 32'h0000_0000, 1'b0);
    $display("test reset done");
    // Reserved bits drop, unmapped offset reads zero
    wr(PEGS_OFS_CTRL, 8'hFF);
    rd(PEGS_OFS_CTRL, 8'hC3);
    chk(cut_o, 1'b0);
    wr(PEGS_OFS_INDEX, 8'hFF);
    rd(PEGS_OFS_INDEX, 8'h7F);
    ce_i = 1'b0;
    wr(PEGS_OFS_INDEX, 8'h11);
    ce_i = 1'b1;
    rd(PEGS_OFS_INDEX, 8'h7F);
    rd(12'h0921, 8'h00);
    $display("test registers done");
    // Separate entries per index, far index included
    for (int i = 0; i < 4; i++) entry(7'(i), sched[i], 1'b1);
    entry(7'h7F, {3'b011, 29'h1ABC_DEF0}, 1'b1);
    for (int i = 0; i < 4; i++) entry(7'(i), sched[i], 1'b0);
    entry(7'h7F, {3'b011, 29'h1ABC_DEF0}, 1'b0);
    $display("test table done");
    // Each reference mode ignores one other mode's pulse, then starts on its own pulse
    shaper_i = PEGS_SHAPER_GATED;
    for (int m = 1; m < 4; m++) begin
      wr(PEGS_OFS_CTRL, 8'h40);
      wr(PEGS_OFS_CTRL, 8'h40 | 8'(m));
      @(negedge clk_i);
      pulse_i = 3'(1 << (m % 3));
      @(negedge clk_i);
      pulse_i = '0;
      repeat (8) @(negedge clk_i);
      chk(open_o, 1'b0);
      pulse_i = 3'(1 << (m - 1));
      @(negedge clk_i);
      pulse_i = '0;
      base = cyc;
      for (int k = 0; k < 8; k++) begin
        repeat (base + ns[k] - cyc) @(negedge clk_i);
        chk({open_o, guard_o, allow_o}, ev[k]);
      end
    end
    $display("test schedule done");
    // Closed and restricted blocks; other shaper modes do not
    wr(PEGS_OFS_CTRL, 8'h40);
    repeat (2) @(negedge clk_i);
    chk(allow_o, 1'b0);
    shaper_i = 2'b00;
    repeat (2) @(negedge clk_i);
    chk(allow_o, 1'b1);
    shaper_i = PEGS_SHAPER_GATED;
    wr(PEGS_OFS_CTRL, 8'h80);
    repeat (2) @(negedge clk_i);
    chk({cut_o, open_o, allow_o}, 3'b101);
    $display("test gating done");
    final_report();
  end
endmodule : test_pegs_gate_sched
